/* logic/dio_defines.svh */
`ifndef DIO_DEFINES_SVH
`define DIO_DEFINES_SVH

// Pin vector positions, lowest is target select bit 0
`define DIO_PIN_W 10
`define DIO_PIN_ENC_A 4
`define DIO_PIN_ENC_B 5
`define DIO_PIN_START 6
`define DIO_PIN_END0 7
`define DIO_PIN_END1 8
`define DIO_PIN_ENABLE 9

// Register indices on the plain register port
`define DIO_ADDR_W 4
`define DIO_REG_CTRL 4'h0
`define DIO_REG_LINES 4'h1
`define DIO_REG_GPOUT 4'h2
`define DIO_REG_MONITOR 4'h3
`define DIO_REG_POS 4'h4
`define DIO_REG_STATUS 4'h5

// Control register fields
`define DIO_CTRL_OUT_SEL 0
`define DIO_CTRL_ENC_IN 1
`define DIO_CTRL_PULSE_DIR 2
`define DIO_CTRL_IDX_SYNC 3
`define DIO_CTRL_ANALOG_SETPOINT_IN0_EN 4
`define DIO_CTRL_ANALOG_SETPOINT_IN1_EN 5
`define DIO_CTRL_ANALOG_SETPOINT_IN0_SPD 6
`define DIO_CTRL_ANALOG_SETPOINT_IN1_SPD 7
`define DIO_CTRL_RST 8'h00

// Line count register fields: code n means 32 << n lines
`define DIO_LINES_IN_LSB 0
`define DIO_LINES_OUT_LSB 4
`define DIO_LINE_CODE_RST 3'h5
`define DIO_LINE_CODE_MAX 3'h5
`define DIO_INCR_BASE 13'h0080
`define DIO_ANGLE_SHIFT_BASE 4'h9

// Status register fields
`define DIO_STAT_ERR 12
`define DIO_STAT_EN 13
`define DIO_STAT_READY 14

// Widths
`define DIO_ADC_W 12
`define DIO_MON_W 8
`define DIO_POS_W 12
`define DIO_ANGLE_W 16
`define DIO_DIV_W 5

// Timing
`define DIO_CLK_MHZ 250
`define DIO_EMU_STEP_NS 100
`define DIO_EMU_STEP_CYC ((`DIO_EMU_STEP_NS * `DIO_CLK_MHZ) / 1000)

`endif

/* logic/dio_pkg.sv */
`include "dio_defines.svh"

package dio_pkg;

	typedef struct packed {
		logic [`DIO_PIN_W-1:0] s1;
		logic [`DIO_PIN_W-1:0] s2;
		logic [`DIO_PIN_W-1:0] s3;
		logic [`DIO_PIN_W-1:0] filt;
		logic [7:0] ctrl;
		logic [2:0] inCode;
		logic [2:0] outCode;
		logic [1:0] gp;
		logic [`DIO_MON_W-1:0] mon;
		logic [`DIO_POS_W-1:0] pos;
		logic errPend;
		logic enable;
		logic ready;
		logic brake;
		logic ack;
		logic start;
		logic outA;
		logic outB;
		logic [3:0] tIdx;
		logic [1:0] tGrp;
		logic [1:0] endSw;
		logic [`DIO_ADC_W-1:0] curSp;
		logic [`DIO_ADC_W-1:0] spdSp;
		logic [31:0] rdata;
	} dio_port_state_type;

	typedef struct packed {
		logic [`DIO_DIV_W-1:0] div;
		logic [`DIO_POS_W-1:0] cur;
		logic a;
		logic b;
	} dio_emu_state_type;

	function automatic logic [2:0] clampCode(input logic [2:0] c);
		return (c > `DIO_LINE_CODE_MAX) ? `DIO_LINE_CODE_MAX : c;
	endfunction: clampCode

	// Increments per revolution minus one, four per line
	function automatic logic [`DIO_POS_W-1:0] incMask(input logic [2:0] c);
		logic [12:0] n;
		n = `DIO_INCR_BASE << clampCode(c);
		return `DIO_POS_W'(n - 13'h0001);
	endfunction: incMask

endpackage: dio_pkg

/* logic/dio_emu_if.sv */
`timescale 1ns/1ps
`include "dio_defines.svh"

interface dio_emu_if;
	logic [`DIO_ANGLE_W-1:0] angle;
	logic [2:0] lineCode;
	logic trackA;
	logic trackB;
	modport host(output angle, output lineCode, input trackA, input trackB);
	modport emu(input angle, input lineCode, output trackA, output trackB);
endinterface: dio_emu_if

/* logic/dio_enc_emu.sv */
`timescale 1ns/1ps
`include "dio_defines.svh"

module dio_enc_emu #(
	parameter int STEP_CYC = `DIO_EMU_STEP_CYC
) (
	input wire logic clk, // System clock
	input wire logic nrst, // Async reset
	dio_emu_if.emu bus // Angle in, tracks out
);
	dio_pkg::dio_emu_state_type st;
	dio_pkg::dio_emu_state_type next_st;
	logic step;
	logic [`DIO_POS_W-1:0] mask;
	logic [`DIO_POS_W-1:0] target;
	logic [`DIO_POS_W-1:0] diff;
	logic [3:0] shift;

	assign step = (st.div == `DIO_DIV_W'(STEP_CYC - 1));
	assign mask = dio_pkg::incMask(bus.lineCode);
	assign shift = `DIO_ANGLE_SHIFT_BASE - {1'b0, dio_pkg::clampCode(bus.lineCode)};
	assign target = `DIO_POS_W'(bus.angle >> shift) & mask; // R16
	assign diff = (target - st.cur) & mask;

	always_comb begin
		next_st = st;
		next_st.div = step ? '0 : `DIO_DIV_W'(st.div + 1'b1);
		next_st.cur = st.cur & mask;
		// One edge per step, the short way round, so A and B never jump
		if (step && diff != '0) begin
			if (diff > (mask >> 1)) begin
				next_st.cur = (st.cur - 1'b1) & mask; // R18
			end else begin
				next_st.cur = (st.cur + 1'b1) & mask; // R18
			end
		end
		next_st.a = next_st.cur[1] ^ next_st.cur[0]; // R17
		next_st.b = next_st.cur[1]; // R17
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign bus.trackA = st.a;
	assign bus.trackB = st.b;

	property p_emu_one_track;
		@(posedge clk) disable iff (!nrst) !($changed(st.a) && $changed(st.b));
	endproperty
	a_emu_one_track: assert property (p_emu_one_track) else $error("both tracks moved"); // R17

	property p_emu_step_rate;
		@(posedge clk) disable iff (!nrst)
			$changed(st.cur) && $past(bus.lineCode, 2) == $past(bus.lineCode) |-> $past(step);
	endproperty
	a_emu_step_rate: assert property (p_emu_step_rate) else $error("edge off step"); // R18

	property p_emu_cov_move;
		@(posedge clk) disable iff (!nrst) $changed(st.a);
	endproperty
	c_emu_cov_move: cover property (p_emu_cov_move);

endmodule: dio_enc_emu

/* logic/dio_port.sv */
// Functional notes
// R1 - Select bits 0-3 pick one of sixteen targets
// R2 - Select bits 4-5 pick target parameter group
// R3 - Start input begins move; two end switches
// R4 - Enable high runs drive; falling edge acknowledges
// R5 - Ready output shows operational state
// R6 - Outputs two, three: general or tracks A/B
// R7 - Dedicated output controls holding brake
// R8 - Analog inputs 12-bit, current or speed setpoint
// R9 - Analog pins share select bits, one use
// R10 - Monitor output from 8-bit code
// R11 - Encoder in and out allow master-slave
// R12 - Encoder input takes A, B, index sync
// R13 - Optional pulse and direction input mode
// R14 - Input line count 32 to 1024
// R15 - Source keeps input rate at 50 kHz
// R16 - Output tracks from rotor angle, own count
// R17 - Emulation gives A and B, no index
// R18 - Emulated output exceeds 100 kHz lines
// R19 - Quadrature: four counts per line, phase direction
// R20 - All inputs synchronised and filtered first; here only the ten pin inputs, not faultIn, adcValid or the analog codes
`timescale 1ns/1ps
`include "dio_defines.svh"

module dio_port (
	input wire logic clk, // System clock
	input wire logic nrst, // Async reset
	input wire logic [`DIO_ADDR_W-1:0] regAddr, // Register index
	input wire logic [31:0] regWdata, // Write data
	input wire logic regWr, // Write strobe
	input wire logic regRd, // Read strobe
	output logic [31:0] regRdata, // Read data, cycle after strobe
	input wire logic targetSelBit0In, // Target bit 0 pin
	input wire logic targetSelBit1In, // Target bit 1 pin
	input wire logic targetSelBit2In, // Target bit 2 pin
	input wire logic targetSelBit3In, // Target bit 3 pin
	input wire logic groupSelBit0EncAIn, // Group bit 0 or track A
	input wire logic groupSelBit1EncBIn, // Group bit 1 or track B
	input wire logic startPosEncNIn, // Start or index
	input wire logic endSwitch0In, // End switch 0
	input wire logic endSwitch1In, // End switch 1
	input wire logic driveEnableAckIn, // Enable, fall acknowledges
	input wire logic faultIn, // Error event from drive core
	input wire logic [`DIO_ANGLE_W-1:0] rotorAngle, // Measured rotor angle
	input wire logic [`DIO_ADC_W-1:0] analogSetpointIn0, // Converter code 0
	input wire logic [`DIO_ADC_W-1:0] analogSetpointIn1, // Converter code 1
	input wire logic adcValid, // Conversion done pulse
	output logic readyOut, // Ready state
	output logic configOutATrack, // General or track A
	output logic configOutBTrack, // General or track B
	output logic brakeOut, // High releases brake
	output logic [`DIO_MON_W-1:0] analogMonitorOut, // Monitor code
	output logic [3:0] targetIndex, // Selected target
	output logic [1:0] targetGroup, // Selected group
	output logic startPulse, // Start move pulse
	output logic [1:0] endSwitch, // End switch levels
	output logic driveEnable, // Drive enabled
	output logic errorAck, // Acknowledge pulse
	output logic errorPending, // Error held
	output logic [`DIO_POS_W-1:0] encPosition, // Input position count
	output logic [`DIO_ADC_W-1:0] currentSetpoint, // Analog current setpoint
	output logic [`DIO_ADC_W-1:0] speedSetpoint // Analog speed setpoint
);
	dio_pkg::dio_port_state_type st;
	dio_pkg::dio_port_state_type next_st;
	dio_emu_if emuBus ();
	logic [`DIO_PIN_W-1:0] pinIn;
	logic [`DIO_PIN_W-1:0] nextFilt;
	logic [`DIO_POS_W-1:0] posMask;
	logic encIn;
	logic pulseDir;
	logic oldA;
	logic newA;
	logic oldB;
	logic newB;
	logic quadStep;
	logic stepUp;
	logic stepDn;
	logic idxHit;
	logic ackNow;

	assign pinIn = {driveEnableAckIn, endSwitch1In, endSwitch0In, startPosEncNIn,
		groupSelBit1EncBIn, groupSelBit0EncAIn, targetSelBit3In, targetSelBit2In,
		targetSelBit1In, targetSelBit0In};

	// A change counts once the second and third stage agree
	always_comb begin
		for (int i = 0; i < `DIO_PIN_W; i++) begin
			nextFilt[i] = (st.s2[i] == st.s3[i]) ? st.s3[i] : st.filt[i]; // R20
		end
	end

	assign encIn = st.ctrl[`DIO_CTRL_ENC_IN];
	assign pulseDir = st.ctrl[`DIO_CTRL_PULSE_DIR];
	assign posMask = dio_pkg::incMask(st.inCode); // R14
	assign oldA = st.filt[`DIO_PIN_ENC_A];
	assign newA = nextFilt[`DIO_PIN_ENC_A];
	assign oldB = st.filt[`DIO_PIN_ENC_B];
	assign newB = nextFilt[`DIO_PIN_ENC_B];
	// Both tracks flipping at once has no direction, so it is dropped
	assign quadStep = (oldA ^ newA) != (oldB ^ newB); // R19
	assign stepUp = encIn & (pulseDir ? (newA & ~oldA & newB)
		: (quadStep & ~(oldA ^ newB))); // R13 R19
	assign stepDn = encIn & (pulseDir ? (newA & ~oldA & ~newB)
		: (quadStep & (oldA ^ newB))); // R13 R19
	assign idxHit = encIn & st.ctrl[`DIO_CTRL_IDX_SYNC]
		& nextFilt[`DIO_PIN_START] & ~st.filt[`DIO_PIN_START]; // R12
	assign ackNow = st.filt[`DIO_PIN_ENABLE] & ~nextFilt[`DIO_PIN_ENABLE]; // R4

	assign emuBus.angle = rotorAngle; // R16
	assign emuBus.lineCode = st.outCode; // R16

	dio_enc_emu #(
		.STEP_CYC(`DIO_EMU_STEP_CYC)
	) emu (
		.clk(clk),
		.nrst(nrst),
		.bus(emuBus.emu)
	);

	always_comb begin
		next_st = st;
		next_st.s1 = pinIn;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.filt = nextFilt;

		if (regWr) begin
			unique case (regAddr)
				`DIO_REG_CTRL: next_st.ctrl = regWdata[7:0];
				`DIO_REG_LINES: begin
					next_st.inCode = dio_pkg::clampCode(regWdata[`DIO_LINES_IN_LSB +: 3]); // R14
					next_st.outCode = dio_pkg::clampCode(regWdata[`DIO_LINES_OUT_LSB +: 3]);
				end
				`DIO_REG_GPOUT: next_st.gp = regWdata[1:0];
				`DIO_REG_MONITOR: next_st.mon = regWdata[`DIO_MON_W-1:0]; // R10
				default: next_st.ctrl = st.ctrl;
			endcase
		end

		// Index wins over a count in the same cycle
		if (idxHit) begin
			next_st.pos = '0; // R12
		end else if (stepUp) begin
			next_st.pos = (st.pos + 1'b1) & posMask; // R11 R19
		end else if (stepDn) begin
			next_st.pos = (st.pos - 1'b1) & posMask; // R11 R19
		end else begin
			next_st.pos = st.pos & posMask;
		end

		// A fault in the acknowledge cycle stays pending
		next_st.errPend = faultIn | (st.errPend & ~ackNow); // R4
		next_st.ack = ackNow; // R4
		next_st.enable = nextFilt[`DIO_PIN_ENABLE]; // R4
		next_st.ready = nextFilt[`DIO_PIN_ENABLE] & ~next_st.errPend; // R5
		next_st.brake = nextFilt[`DIO_PIN_ENABLE] & ~next_st.errPend; // R7

		next_st.tIdx[1:0] = st.ctrl[`DIO_CTRL_ANALOG_SETPOINT_IN0_EN] ? 2'h0 : nextFilt[1:0]; // R1 R9
		next_st.tIdx[3:2] = st.ctrl[`DIO_CTRL_ANALOG_SETPOINT_IN1_EN] ? 2'h0 : nextFilt[3:2]; // R1 R9
		next_st.tGrp = encIn ? 2'h0 : nextFilt[`DIO_PIN_ENC_B:`DIO_PIN_ENC_A]; // R2
		next_st.start = ~encIn & nextFilt[`DIO_PIN_START] & ~st.filt[`DIO_PIN_START]; // R3
		next_st.endSw = nextFilt[`DIO_PIN_END1:`DIO_PIN_END0]; // R3

		if (adcValid && st.ctrl[`DIO_CTRL_ANALOG_SETPOINT_IN0_EN]) begin
			if (st.ctrl[`DIO_CTRL_ANALOG_SETPOINT_IN0_SPD]) begin
				next_st.spdSp = analogSetpointIn0; // R8
			end else begin
				next_st.curSp = analogSetpointIn0; // R8
			end
		end
		// Both channels on one setpoint: channel 1 takes it
		if (adcValid && st.ctrl[`DIO_CTRL_ANALOG_SETPOINT_IN1_EN]) begin
			if (st.ctrl[`DIO_CTRL_ANALOG_SETPOINT_IN1_SPD]) begin
				next_st.spdSp = analogSetpointIn1; // R8
			end else begin
				next_st.curSp = analogSetpointIn1; // R8
			end
		end

		next_st.outA = st.ctrl[`DIO_CTRL_OUT_SEL] ? emuBus.trackA : st.gp[0]; // R6
		next_st.outB = st.ctrl[`DIO_CTRL_OUT_SEL] ? emuBus.trackB : st.gp[1]; // R6

		next_st.rdata = '0;
		if (regRd) begin
			unique case (regAddr)
				`DIO_REG_CTRL: next_st.rdata[7:0] = st.ctrl;
				`DIO_REG_LINES: begin
					next_st.rdata[`DIO_LINES_IN_LSB +: 3] = st.inCode;
					next_st.rdata[`DIO_LINES_OUT_LSB +: 3] = st.outCode;
				end
				`DIO_REG_GPOUT: next_st.rdata[1:0] = st.gp;
				`DIO_REG_MONITOR: next_st.rdata[`DIO_MON_W-1:0] = st.mon;
				`DIO_REG_POS: next_st.rdata[`DIO_POS_W-1:0] = st.pos;
				`DIO_REG_STATUS: begin
					next_st.rdata[`DIO_PIN_W-1:0] = st.filt;
					next_st.rdata[`DIO_STAT_ERR] = st.errPend;
					next_st.rdata[`DIO_STAT_EN] = st.enable;
					next_st.rdata[`DIO_STAT_READY] = st.ready;
				end
				default: next_st.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
			st.ctrl <= `DIO_CTRL_RST;
			st.inCode <= `DIO_LINE_CODE_RST;
			st.outCode <= `DIO_LINE_CODE_RST;
		end else begin
			st <= next_st;
		end
	end

	assign regRdata = st.rdata;
	assign readyOut = st.ready;
	assign configOutATrack = st.outA;
	assign configOutBTrack = st.outB;
	assign brakeOut = st.brake;
	assign analogMonitorOut = st.mon;
	assign targetIndex = st.tIdx;
	assign targetGroup = st.tGrp;
	assign startPulse = st.start;
	assign endSwitch = st.endSw;
	assign driveEnable = st.enable;
	assign errorAck = st.ack;
	assign errorPending = st.errPend;
	assign encPosition = st.pos;
	assign currentSetpoint = st.curSp;
	assign speedSetpoint = st.spdSp;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	property p_filter_delay;
		driveEnableAckIn [*5] |-> driveEnable;
	endproperty
	a_filter_delay: assert property (p_filter_delay) else $error("enable not seen"); // R20

	property p_err_ack;
		$fell(driveEnable) && !$past(faultIn) |-> errorAck && !errorPending;
	endproperty
	a_err_ack: assert property (p_err_ack) else $error("falling edge missed"); // R4

	property p_ready_state;
		readyOut == (driveEnable && !errorPending);
	endproperty
	a_ready_state: assert property (p_ready_state) else $error("ready wrong"); // R5

	property p_brake_follows;
		$rose(errorPending) |-> !brakeOut && !readyOut;
	endproperty
	a_brake_follows: assert property (p_brake_follows) else $error("brake held off"); // R7

	property p_track_out;
		$past(st.ctrl[`DIO_CTRL_OUT_SEL]) |-> configOutATrack == $past(emuBus.trackA)
			&& configOutBTrack == $past(emuBus.trackB);
	endproperty
	a_track_out: assert property (p_track_out) else $error("track output wrong"); // R6

	property p_quad_count;
		stepUp && !idxHit |=> encPosition == (($past(encPosition) + 1'b1) & $past(posMask));
	endproperty
	a_quad_count: assert property (p_quad_count) else $error("count up missed"); // R19

	property p_pulse_dir;
		encIn && pulseDir && newA && !oldA && !newB |-> stepDn && !stepUp;
	endproperty
	a_pulse_dir: assert property (p_pulse_dir) else $error("pulse direction wrong"); // R13

	property p_index_sync;
		idxHit |=> encPosition == '0;
	endproperty
	a_index_sync: assert property (p_index_sync) else $error("index not applied"); // R12

	property p_analog_pins;
		$past(st.ctrl[`DIO_CTRL_ANALOG_SETPOINT_IN0_EN]) |-> targetIndex[1:0] == 2'h0;
	endproperty
	a_analog_pins: assert property (p_analog_pins) else $error("pin pair used twice"); // R9

	property p_target_sel;
		!$past(st.ctrl[`DIO_CTRL_ANALOG_SETPOINT_IN1_EN]) |-> targetIndex[3:2] == $past(nextFilt[3:2]);
	endproperty
	a_target_sel: assert property (p_target_sel) else $error("target bits wrong"); // R1

	property p_analog_cur;
		adcValid && st.ctrl[`DIO_CTRL_ANALOG_SETPOINT_IN0_EN] && !st.ctrl[`DIO_CTRL_ANALOG_SETPOINT_IN0_SPD]
			&& !st.ctrl[`DIO_CTRL_ANALOG_SETPOINT_IN1_EN] |=> currentSetpoint == $past(analogSetpointIn0);
	endproperty
	a_analog_cur: assert property (p_analog_cur) else $error("setpoint not taken"); // R8

	property p_read_latency;
		regRd && regAddr == `DIO_REG_MONITOR |=> regRdata[`DIO_MON_W-1:0] == analogMonitorOut;
	endproperty
	a_read_latency: assert property (p_read_latency) else $error("read data wrong");

	property p_read_idle;
		!$past(regRd) |-> regRdata == '0;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data held");

	property p_monitor_write;
		regWr && regAddr == `DIO_REG_MONITOR
			|=> analogMonitorOut == $past(regWdata[`DIO_MON_W-1:0]);
	endproperty
	a_monitor_write: assert property (p_monitor_write) else $error("monitor not written"); // R10

	property p_start_refused;
		encIn |=> !startPulse;
	endproperty
	a_start_refused: assert property (p_start_refused) else $error("start in encoder mode"); // R3

	property p_group_sel;
		!encIn |=> targetGroup == $past(nextFilt[`DIO_PIN_ENC_B:`DIO_PIN_ENC_A]);
	endproperty
	a_group_sel: assert property (p_group_sel) else $error("group bits wrong"); // R2

	property p_ack_single;
		errorAck |=> !errorAck;
	endproperty
	a_ack_single: assert property (p_ack_single) else $error("acknowledge too long"); // R4

	property p_fault_wins;
		faultIn |=> errorPending;
	endproperty
	a_fault_wins: assert property (p_fault_wins) else $error("fault lost"); // R4

	property p_brake_release;
		brakeOut |-> driveEnable && !errorPending;
	endproperty
	a_brake_release: assert property (p_brake_release) else $error("brake released wrongly"); // R7

	property p_count_down;
		stepDn && !idxHit |=> encPosition == (($past(encPosition) - 1'b1) & $past(posMask));
	endproperty
	a_count_down: assert property (p_count_down) else $error("count down missed"); // R19

	property p_pos_range;
		(encPosition & ~$past(posMask)) == '0;
	endproperty
	a_pos_range: assert property (p_pos_range) else $error("count outside line range"); // R14

	c_index: cover property (idxHit);
	c_error_ack: cover property (errorPending ##1 errorAck);
	c_pulse_step: cover property (encIn && pulseDir && stepUp);
	c_track_toggle: cover property (st.ctrl[`DIO_CTRL_OUT_SEL] && $changed(configOutATrack));

endmodule: dio_port

/* tb/dio_plc_model.sv */
`timescale 1ns/1ps

module dio_plc_model (
	output logic [9:0] pins, // Controller pin levels
	input wire logic clk // System clock
);
	// Input rate kept at 50 kHz lines: four edges per line at 250 MHz
	localparam int EDGE_GAP = 1250;
	logic [1:0] ph;

	initial begin
		pins = 10'h000;
		ph = 2'h0;
	end

	task automatic setPins(input logic [9:0] v);
		@(posedge clk);
		pins <= v;
	endtask: setPins

	task automatic gap();
		repeat (EDGE_GAP) @(posedge clk);
	endtask: gap

	// One track moves per edge, so the phase order carries direction
	task automatic quad(input int edges, input logic up);
		for (int i = 0; i < edges; i++) begin
			ph = up ? ph + 2'h1 : ph - 2'h1;
			@(posedge clk);
			pins[5:4] <= {ph[1], ph[1] ^ ph[0]};
			gap();
		end
	endtask: quad

	task automatic pulses(input int n);
		@(posedge clk);
		pins[5] <= 1'b1;
		gap();
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			pins[4] <= 1'b1;
			gap();
			@(posedge clk);
			pins[4] <= 1'b0;
			gap();
		end
	endtask: pulses

	task automatic index();
		@(posedge clk);
		pins[6] <= 1'b1;
		gap();
		@(posedge clk);
		pins[6] <= 1'b0;
		gap();
	endtask: index
endmodule: dio_plc_model

/* tb/dio_port_bench.sv */
`timescale 1ns/1ps
`include "dio_defines.svh"

module dio_port_bench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] regAddr;
	logic [31:0] regWdata;
	logic regWr;
	logic regRd;
	logic [31:0] regRdata;
	logic faultIn;
	logic [15:0] rotorAngle;
	logic [11:0] analog_setpoint_in0;
	logic [11:0] analog_setpoint_in1;
	logic adcValid;
	logic readyOut, outA, outB, brakeOut, startPulse, driveEnable, errorAck, errorPending;
	logic [7:0] monitor;
	logic [3:0] targetIndex;
	logic [1:0] targetGroup, endSwitch;
	logic [11:0] encPosition, curSp, spdSp;
	logic [9:0] pins;
	logic [31:0] seed, d, a0, a1;
	int n_fail = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;

	always #2 clk = ~clk;

	dio_plc_model u_dio_plc_model (.pins(pins), .clk(clk));

	dio_port u_dio_port (
		.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .targetSelBit0In(pins[0]),
		.targetSelBit1In(pins[1]), .targetSelBit2In(pins[2]), .targetSelBit3In(pins[3]),
		.groupSelBit0EncAIn(pins[4]), .groupSelBit1EncBIn(pins[5]), .startPosEncNIn(pins[6]),
		.endSwitch0In(pins[7]), .endSwitch1In(pins[8]), .driveEnableAckIn(pins[9]),
		.faultIn(faultIn), .rotorAngle(rotorAngle), .analogSetpointIn0(analog_setpoint_in0),
		.analogSetpointIn1(analog_setpoint_in1), .adcValid(adcValid), .readyOut(readyOut),
		.configOutATrack(outA), .configOutBTrack(outB), .brakeOut(brakeOut),
		.analogMonitorOut(monitor), .targetIndex(targetIndex), .targetGroup(targetGroup),
		.startPulse(startPulse), .endSwitch(endSwitch), .driveEnable(driveEnable),
		.errorAck(errorAck), .errorPending(errorPending), .encPosition(encPosition),
		.currentSetpoint(curSp), .speedSetpoint(spdSp)
	);

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction: xs

	function automatic logic [11:0] posExp(input int incr, input int code);
		return 12'(incr & ((128 << code) - 1));
	endfunction: posExp

	// Emulated tracks {B,A} for an increment count
	function automatic logic [1:0] trackExp(input int incr);
		case (incr % 4)
			0: return 2'b00;
			1: return 2'b01;
			2: return 2'b11;
			default: return 2'b10;
		endcase
	endfunction: trackExp

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask: tally_and_finish

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask: chk

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask: tick

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask: wr

	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 v = regRdata;
	endtask: rd

	task automatic adc();
		seed = xs(seed);
		a0 = {20'h0, seed[11:0]};
		a1 = {20'h0, seed[27:16]};
		@(posedge clk);
		analog_setpoint_in0 <= a0[11:0];
		analog_setpoint_in1 <= a1[11:0];
		adcValid <= 1'b1;
		@(posedge clk);
		adcValid <= 1'b0;
	endtask: adc

	// Pulse outputs must show for exactly one cycle per cause
	task automatic countPulses(input bit err);
		n = 0;
		repeat (12) begin
			tick(1);
			if ((err ? errorAck : startPulse) === 1'b1)
				n++;
		end
	endtask: countPulses

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	initial begin
		seed = 32'h68482302;
		regAddr <= 4'h0;
		regWdata <= seed;
		regWr <= 1'b0;
		regRd <= 1'b0;
		faultIn <= 1'b0;
		rotorAngle <= 16'h0000;
		analog_setpoint_in0 <= seed[11:0];
		analog_setpoint_in1 <= seed[27:16];
		adcValid <= 1'b0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		rd(`DIO_REG_CTRL, d); chk("ctrl reset", 32'h0, d);
		rd(`DIO_REG_LINES, d); chk("lines reset", 32'h55, d);
		wr(`DIO_REG_LINES, 32'h77); rd(`DIO_REG_LINES, d); chk("lines clamp", 32'h55, d);
		wr(4'hF, 32'hFFFFFFFF); rd(4'hF, d); chk("unmapped", 32'h0, d);
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			u_dio_plc_model.setPins({4'h0, seed[5:0]});
			tick(8);
			chk("target index", seed[3:0], targetIndex);
			chk("target group", seed[5:4], targetGroup);
			rd(`DIO_REG_STATUS, d); chk("status pins", seed[5:0], d[9:0]);
		end
		u_dio_plc_model.setPins(10'h180); tick(8);
		chk("end switches", 2'h3, endSwitch);
		u_dio_plc_model.setPins(10'h1C0); countPulses(1'b0);
		chk("start pulses", 1, n);
		@(posedge clk) faultIn <= 1'b1;
		@(posedge clk) faultIn <= 1'b0;
		tick(2); chk("error set", 1'b1, errorPending);
		u_dio_plc_model.setPins(10'h200); tick(8);
		chk("enable", 1'b1, driveEnable);
		chk("ready in error", 1'b0, readyOut);
		chk("brake in error", 1'b0, brakeOut);
		u_dio_plc_model.setPins(10'h000); countPulses(1'b1);
		chk("ack pulses", 1, n);
		chk("error cleared", 1'b0, errorPending);
		u_dio_plc_model.setPins(10'h200); tick(8);
		chk("ready", 1'b1, readyOut);
		chk("brake", 1'b1, brakeOut);
		rd(`DIO_REG_STATUS, d); chk("status state", 3'h6, d[14:12]);
		for (int i = 0; i < 3; i++) begin
			seed = xs(seed);
			wr(`DIO_REG_GPOUT, {30'h0, seed[1:0]});
			wr(`DIO_REG_MONITOR, {24'h0, seed[15:8]});
			tick(3);
			chk("general outputs", seed[1:0], {outB, outA});
			chk("monitor", seed[15:8], monitor);
		end
		u_dio_plc_model.setPins(10'h00F);
		wr(`DIO_REG_CTRL, 32'h10); adc(); tick(8);
		chk("current setpoint", a0, curSp);
		chk("pins shared", 4'hC, targetIndex);
		wr(`DIO_REG_CTRL, 32'h70); adc(); tick(8);
		chk("speed setpoint", a0, spdSp);
		chk("current from second", a1, curSp);
		chk("both pairs shared", 4'h0, targetIndex);
		wr(`DIO_REG_CTRL, 32'hB0); adc(); tick(8);
		chk("speed from second", a1, spdSp);
		chk("current from first", a0, curSp);
		u_dio_plc_model.setPins(10'h000);
		wr(`DIO_REG_LINES, 32'h00);
		wr(`DIO_REG_CTRL, 32'h0A);
		u_dio_plc_model.quad(8, 1'b1); tick(8);
		chk("quad forward", posExp(8, 0), encPosition);
		chk("group claimed", 2'h0, targetGroup);
		u_dio_plc_model.index(); tick(8);
		chk("index sync", 12'h0, encPosition);
		u_dio_plc_model.quad(4, 1'b0); tick(8);
		chk("quad back", posExp(-4, 0), encPosition);
		wr(`DIO_REG_CTRL, 32'h06);
		u_dio_plc_model.pulses(4); tick(8);
		chk("pulse direction", posExp(0, 0), encPosition);
		rd(`DIO_REG_POS, d); chk("position reg", 32'h0, d);
		wr(`DIO_REG_CTRL, 32'h01);
		u_dio_plc_model.setPins(10'h000);
		@(posedge clk) rotorAngle <= 16'h0400;
		tick(200); chk("emulated tracks", trackExp(2), {outB, outA});
		@(posedge clk) rotorAngle <= 16'h0600;
		tick(200); chk("emulated tracks", trackExp(3), {outB, outA});
		seed = xs(seed);
		@(posedge clk) rotorAngle <= seed[15:0];
		tick(1700); chk("emulated random", trackExp(seed[10:9]), {outB, outA});
		tally_and_finish();
	end
endmodule: dio_port_bench
